/* File: include/liu_regs_pkg.sv */
// Constants, layouts and types for the four-channel line interface register map
// What this block does
// (RULE1) Channel registers repeat at channel-one offset plus 0x40 per channel.
// (RULE2) Any write to soft reset returns all registers and ports to defaults.
// (RULE3) Soft reset register stores nothing; writes only trigger the reset.
// (RULE4) Global config bit 4 picks line standard: 0 E1, 1 T1/J1.
// (RULE5) Global config bit 3 copies channel writes to every channel.
// (RULE6) Global config bit 2, default 1, disables all interrupts; else masks gate.
// (RULE7) Bits 1:0 pick pin drive: x0 open-drain low, 01 push-pull low, 11 high.
// (RULE8) Host keeps global config bit 5 zero; bits 7:6 reserved zero.
// (RULE9) Lowest global address reads the eight-bit revision code.
// (RULE10) Soft reset completes within one microsecond.
// (RULE11) Channel-indication bits 0,2,4,6 flag channels 1 to 4 interrupting.
// (RULE12) Globally enabled, pin goes active while any unmasked interrupt pends.
// (RULE13) Reserved bits and addresses read zero and ignore writes.
package liu_regs_pkg;
    localparam int NUM_CH = 4;
    localparam logic [7:0] OFS_REVISION = 8'h00;
    localparam logic [7:0] OFS_SOFT_RESET = 8'h20;
    localparam logic [7:0] OFS_GLOBAL_CFG0 = 8'h40;
    localparam logic [7:0] OFS_IRQ_CHANNEL = 8'h80;
    localparam logic [7:0] OFS_RESERVED_A0 = 8'ha0;
    localparam logic [4:0] OFS_JITTER = 5'h01;
    localparam logic [4:0] OFS_TX_INBAND = 5'h0d;
    localparam logic [4:0] OFS_MASK_A = 5'h11;
    localparam logic [4:0] OFS_MASK_B = 5'h12;
    localparam logic [4:0] OFS_EDGE_SEL = 5'h13;
    localparam logic [4:0] OFS_STATUS_A = 5'h14;
    localparam logic [4:0] OFS_STATUS_B = 5'h15;
    localparam logic [4:0] OFS_FLAGS_A = 5'h16;
    localparam logic [4:0] OFS_FLAGS_B = 5'h17;
    localparam logic [4:0] OFS_COUNT_LO = 5'h18;
    localparam logic [4:0] OFS_COUNT_HI = 5'h19;
    localparam int GCFG_STD_BIT = 4;
    localparam int GCFG_COPY_BIT = 3;
    localparam int GCFG_IRQ_DIS_BIT = 2;
    localparam logic [7:0] GCFG_RST = 8'h04;
    localparam logic [7:0] GCFG_WMASK = 8'h1f;
    localparam logic [7:0] STATUS_A_MASK = 8'h7f;
    localparam logic [7:0] STATUS_B_MASK = 8'h20;
    localparam logic [7:0] FLAGS_A_MASK = 8'h7f;
    localparam logic [7:0] FLAGS_B_MASK = 8'hff;
    localparam int SW_RESET_NS = 1000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SW_RESET_CYCLES = SW_RESET_NS / CLK_PERIOD_NS;

    // Writable bits of each plain configuration register
    function automatic logic [7:0] cfg_wmask(input logic [4:0] ofs);
        case (ofs)
            5'h01, 5'h03, 5'h04, 5'h0c, 5'h1a: cfg_wmask = 8'h3f;
            5'h02, 5'h07: cfg_wmask = 8'h1f;
            5'h05, 5'h0d, 5'h0e, 5'h0f, 5'h12: cfg_wmask = 8'hff;
            5'h06, 5'h0a, 5'h10, 5'h11, 5'h13: cfg_wmask = 8'h7f;
            5'h08: cfg_wmask = 8'h5f;
            5'h09: cfg_wmask = 8'h33;
            5'h0b: cfg_wmask = 8'h0f;
            default: cfg_wmask = 8'h00;
        endcase
    endfunction

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic [7:0] status_a;
        logic [7:0] status_b;
        logic [7:0] events;
        logic [15:0] err_count;
    } chan_in_s;

    typedef logic [31:0][7:0] chan_regs_t;
endpackage

/* File: rtl/quad_liu_register_map.sv */
// Register map of a four-channel line interface: globals, channel banks, interrupt pin
`timescale 1ns/1ps
module quad_liu_register_map #(
    parameter logic [7:0] REVISION = 8'h5a // Arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire liu_regs_pkg::bus_req_s bus_i,
    input wire liu_regs_pkg::chan_in_s [liu_regs_pkg::NUM_CH-1:0] chan_i,
    output logic [7:0] rdata_o,
    output liu_regs_pkg::chan_regs_t [liu_regs_pkg::NUM_CH-1:0] chan_cfg_o,
    output logic line_standard_select_o,
    output logic irq_pin_o,
    output logic irq_pin_oe_o
);
    localparam int NCH = liu_regs_pkg::NUM_CH;

    typedef struct packed {
        logic [7:0] gcfg;
        liu_regs_pkg::chan_regs_t [NCH-1:0] creg;
        logic [NCH-1:0][6:0] stat_prev;
        logic [7:0] rdata;
        logic pin;
        logic pin_oe;
    } state_s;

    localparam state_s ST_RST = '{gcfg: liu_regs_pkg::GCFG_RST, default: '0};

    state_s state_reg;
    state_s state_next;

    logic chan_hit;
    logic [1:0] chan_sel;
    logic [4:0] ofs;
    logic copy_on;
    logic sw_rst;
    logic [NCH-1:0] pend;
    logic irq_any;
    logic [7:0] rd_val;

    assign ofs = bus_i.addr[4:0];
    assign chan_sel = bus_i.addr[7:6];
    // Offsets 0x01..0x1f of each block belong to a channel
    assign chan_hit = (bus_i.addr[5] == 1'b0) && (ofs != 5'h00); // see (RULE1)
    assign copy_on = state_reg.gcfg[liu_regs_pkg::GCFG_COPY_BIT];
    assign sw_rst = bus_i.wr && (bus_i.addr == liu_regs_pkg::OFS_SOFT_RESET); // see (RULE2)

    // Pending unmasked flags per channel; mask bit 1 enables a source
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            pend[c] = |(state_reg.creg[c][liu_regs_pkg::OFS_FLAGS_A]
                        & state_reg.creg[c][liu_regs_pkg::OFS_MASK_A])
                    || |(state_reg.creg[c][liu_regs_pkg::OFS_FLAGS_B]
                        & state_reg.creg[c][liu_regs_pkg::OFS_MASK_B]); // see (RULE6)
        end
    end

    assign irq_any = !state_reg.gcfg[liu_regs_pkg::GCFG_IRQ_DIS_BIT] && (|pend); // see (RULE6) (RULE12)

    // Read mux; live status and counter come straight from the line logic
    always_comb begin
        logic [7:0] chv;
        chv = 8'h00;
        rd_val = 8'h00;
        if (chan_hit) begin
            case (ofs)
                liu_regs_pkg::OFS_STATUS_A: chv = chan_i[chan_sel].status_a & liu_regs_pkg::STATUS_A_MASK;
                liu_regs_pkg::OFS_STATUS_B: chv = chan_i[chan_sel].status_b & liu_regs_pkg::STATUS_B_MASK;
                liu_regs_pkg::OFS_FLAGS_A, liu_regs_pkg::OFS_FLAGS_B: chv = state_reg.creg[chan_sel][ofs];
                liu_regs_pkg::OFS_COUNT_LO: chv = chan_i[chan_sel].err_count[7:0];
                liu_regs_pkg::OFS_COUNT_HI: chv = chan_i[chan_sel].err_count[15:8];
                default: chv = state_reg.creg[chan_sel][ofs] & liu_regs_pkg::cfg_wmask(ofs); // see (RULE13)
            endcase
            rd_val = chv;
        end else begin
            case (bus_i.addr)
                liu_regs_pkg::OFS_REVISION: rd_val = REVISION; // see (RULE9)
                liu_regs_pkg::OFS_GLOBAL_CFG0: rd_val = state_reg.gcfg;
                liu_regs_pkg::OFS_IRQ_CHANNEL: begin
                    for (int c = 0; c < NCH; c++) begin
                        rd_val[2*c] = pend[c]; // see (RULE11)
                    end
                end
                // Soft reset stores nothing, so it reads as zero
                default: rd_val = 8'h00; // see (RULE3) (RULE13)
            endcase
        end
    end

    always_comb begin
        logic [7:0] wm;
        logic [6:0] rise;
        logic [6:0] chg;
        logic [7:0] set_a;
        wm = liu_regs_pkg::cfg_wmask(ofs);
        rise = '0;
        chg = '0;
        set_a = '0;
        state_next = state_reg;
        state_next.rdata = 8'h00;
        if (bus_i.rd) begin
            state_next.rdata = rd_val;
        end
        if (bus_i.wr && (bus_i.addr == liu_regs_pkg::OFS_GLOBAL_CFG0)) begin
            // Bit 5 and reserved bits 7:6 never stored
            state_next.gcfg = bus_i.wdata & liu_regs_pkg::GCFG_WMASK; // see (RULE4) (RULE8) (RULE13)
        end
        for (int c = 0; c < NCH; c++) begin
            if (bus_i.wr && chan_hit && ((chan_sel == 2'(c)) || copy_on)) begin // see (RULE1) (RULE5)
                if (ofs == liu_regs_pkg::OFS_FLAGS_A) begin
                    state_next.creg[c][ofs] = state_reg.creg[c][ofs]
                        & ~(bus_i.wdata & liu_regs_pkg::FLAGS_A_MASK);
                end else if (ofs == liu_regs_pkg::OFS_FLAGS_B) begin
                    state_next.creg[c][ofs] = state_reg.creg[c][ofs]
                        & ~(bus_i.wdata & liu_regs_pkg::FLAGS_B_MASK);
                end else begin
                    state_next.creg[c][ofs] = (state_reg.creg[c][ofs] & ~wm) | (bus_i.wdata & wm); // see (RULE13)
                end
            end
            // Edge select 0 catches a rise, 1 catches any change
            rise = chan_i[c].status_a[6:0] & ~state_reg.stat_prev[c];
            chg = chan_i[c].status_a[6:0] ^ state_reg.stat_prev[c];
            set_a = {1'b0, (state_reg.creg[c][liu_regs_pkg::OFS_EDGE_SEL][6:0] & chg)
                     | (~state_reg.creg[c][liu_regs_pkg::OFS_EDGE_SEL][6:0] & rise)};
            // Set applied after clear so a new event is never lost to a clearing write
            state_next.creg[c][liu_regs_pkg::OFS_FLAGS_A] =
                state_next.creg[c][liu_regs_pkg::OFS_FLAGS_A] | set_a;
            state_next.creg[c][liu_regs_pkg::OFS_FLAGS_B] =
                state_next.creg[c][liu_regs_pkg::OFS_FLAGS_B] | chan_i[c].events;
            state_next.stat_prev[c] = chan_i[c].status_a[6:0];
        end
        // Pin drive mode; bit 0 low means open drain
        if (!state_reg.gcfg[0]) begin
            state_next.pin = 1'b0; // see (RULE7)
            state_next.pin_oe = irq_any; // see (RULE12)
        end else begin
            state_next.pin_oe = 1'b1; // see (RULE7)
            state_next.pin = state_reg.gcfg[1] ? irq_any : !irq_any; // see (RULE7) (RULE12)
        end
        // Takes effect at the next edge, far inside the one microsecond budget
        if (sw_rst) begin
            state_next = ST_RST; // see (RULE2) (RULE10)
            state_next.stat_prev = state_reg.stat_prev;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata_o = state_reg.rdata;
    assign chan_cfg_o = state_reg.creg;
    assign line_standard_select_o = state_reg.gcfg[liu_regs_pkg::GCFG_STD_BIT];
    assign irq_pin_o = state_reg.pin;
    assign irq_pin_oe_o = state_reg.pin_oe;

    // Checks
    localparam int SW_MAX = 200;
    logic pin_active;
    assign pin_active = irq_pin_oe_o && (irq_pin_o == (state_reg.gcfg[1:0] == 2'b11));

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_rev_read;
        bus_i.rd && (bus_i.addr == liu_regs_pkg::OFS_REVISION) |=> rdata_o == REVISION;
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision read wrong"); // see (RULE9)

    property p_rst_reads_zero;
        bus_i.rd && (bus_i.addr == liu_regs_pkg::OFS_SOFT_RESET) |=> rdata_o == 8'h00;
    endproperty
    a_rst_reads_zero: assert property (p_rst_reads_zero) else $error("reset register read nonzero"); // see (RULE3)

    property p_sw_reset;
        sw_rst |-> ##[1:SW_MAX] (state_reg.gcfg == liu_regs_pkg::GCFG_RST) && !irq_pin_oe_o
            && (state_reg.creg[0][liu_regs_pkg::OFS_JITTER] == 8'h00);
    endproperty
    a_sw_reset: assert property (p_sw_reset) else $error("soft reset incomplete"); // see (RULE2) (RULE10)

    property p_std_select;
        bus_i.wr && (bus_i.addr == liu_regs_pkg::OFS_GLOBAL_CFG0)
            |=> line_standard_select_o == $past(bus_i.wdata[4]) && state_reg.gcfg[7:5] == 3'b000;
    endproperty
    a_std_select: assert property (p_std_select) else $error("line standard not taken"); // see (RULE4)

    property p_broadcast;
        bus_i.wr && copy_on && chan_hit && (ofs == liu_regs_pkg::OFS_TX_INBAND)
            |=> (state_reg.creg[0][liu_regs_pkg::OFS_TX_INBAND] == $past(bus_i.wdata))
            && (state_reg.creg[3][liu_regs_pkg::OFS_TX_INBAND] == $past(bus_i.wdata));
    endproperty
    a_broadcast: assert property (p_broadcast) else $error("broadcast write missed"); // see (RULE5)

    property p_single_write;
        bus_i.wr && !copy_on && chan_hit && (ofs == liu_regs_pkg::OFS_TX_INBAND) && (chan_sel == 2'd2)
            |=> (state_reg.creg[2][liu_regs_pkg::OFS_TX_INBAND] == $past(bus_i.wdata))
            && $stable(state_reg.creg[1][liu_regs_pkg::OFS_TX_INBAND]);
    endproperty
    a_single_write: assert property (p_single_write) else $error("channel decode wrong"); // see (RULE1)

    // Pin level follows the drive mode in force when it was computed
    property p_global_disable;
        state_reg.gcfg[2] && !sw_rst
            |=> !(irq_pin_oe_o && (irq_pin_o == ($past(state_reg.gcfg[1:0]) == 2'b11)));
    endproperty
    a_global_disable: assert property (p_global_disable) else $error("pin active while disabled"); // see (RULE6)

    property p_pin_mode;
        (state_reg.gcfg[0] == 1'b0 && !sw_rst |=> irq_pin_o == 1'b0)
        and (state_reg.gcfg[0] && !sw_rst |=> irq_pin_oe_o);
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("pin drive mode wrong"); // see (RULE7)

    property p_pin_active;
        irq_any && !sw_rst
            |=> irq_pin_oe_o && (irq_pin_o == ($past(state_reg.gcfg[1:0]) == 2'b11));
    endproperty
    a_pin_active: assert property (p_pin_active) else $error("pending interrupt not on pin"); // see (RULE12)

    property p_chan_flags;
        bus_i.rd && (bus_i.addr == liu_regs_pkg::OFS_IRQ_CHANNEL)
            |=> rdata_o[0] == $past(pend[0]) && rdata_o[6] == $past(pend[3]) && rdata_o[1] == 1'b0;
    endproperty
    a_chan_flags: assert property (p_chan_flags) else $error("channel indication wrong"); // see (RULE11)

    property p_reserved;
        bus_i.rd && (bus_i.addr == liu_regs_pkg::OFS_RESERVED_A0) |=> rdata_o == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved address nonzero"); // see (RULE13)

    property p_rdata_idle;
        !bus_i.rd |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle"); // see (RULE13)

    property p_gcfg_rsvd;
        state_reg.gcfg[7:5] == 3'b000;
    endproperty
    a_gcfg_rsvd: assert property (p_gcfg_rsvd) else $error("reserved global bits stored"); // see (RULE8)

    property p_jitter_rsvd;
        state_reg.creg[0][liu_regs_pkg::OFS_JITTER][7:6] == 2'b00;
    endproperty
    a_jitter_rsvd: assert property (p_jitter_rsvd) else $error("reserved channel bits stored"); // see (RULE13)

    property p_gap_read;
        bus_i.rd && bus_i.addr[5] && (ofs != 5'h00) |=> rdata_o == 8'h00;
    endproperty
    a_gap_read: assert property (p_gap_read) else $error("gap address nonzero"); // see (RULE13)

    property p_rsvd_write;
        bus_i.wr && (bus_i.addr == liu_regs_pkg::OFS_RESERVED_A0) |=> $stable(state_reg.gcfg);
    endproperty
    a_rsvd_write: assert property (p_rsvd_write) else $error("reserved write took effect"); // see (RULE13)

    property p_std_hold;
        !(bus_i.wr && ((bus_i.addr == liu_regs_pkg::OFS_GLOBAL_CFG0)
            || (bus_i.addr == liu_regs_pkg::OFS_SOFT_RESET)))
            |=> $stable(line_standard_select_o);
    endproperty
    a_std_hold: assert property (p_std_hold) else $error("line standard moved"); // see (RULE4)

    property p_other_bank;
        bus_i.wr && !copy_on && chan_hit && (chan_sel == 2'd3)
            |=> $stable(state_reg.creg[0][liu_regs_pkg::OFS_TX_INBAND]);
    endproperty
    a_other_bank: assert property (p_other_bank) else $error("write leaked to channel one"); // see (RULE1) (RULE5)

    property p_event_sets;
        chan_i[2].events[0] && !sw_rst
            |=> state_reg.creg[2][liu_regs_pkg::OFS_FLAGS_B][0];
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event flag not set"); // see (RULE12)

    property p_w1c;
        bus_i.wr && !copy_on && chan_hit && (chan_sel == 2'd2) && (ofs == liu_regs_pkg::OFS_FLAGS_B)
            && bus_i.wdata[0] && !chan_i[2].events[0]
            |=> !state_reg.creg[2][liu_regs_pkg::OFS_FLAGS_B][0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared by write"); // see (RULE12)

    // Flag stays until a write of one or a soft reset reaches it
    property p_flag_sticky;
        state_reg.creg[0][liu_regs_pkg::OFS_FLAGS_B][0] && !sw_rst
            && !(bus_i.wr && chan_hit && (ofs == liu_regs_pkg::OFS_FLAGS_B) && bus_i.wdata[0])
            |=> state_reg.creg[0][liu_regs_pkg::OFS_FLAGS_B][0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost"); // see (RULE12)

    property p_rise_sets;
        !state_reg.stat_prev[1][0] && chan_i[1].status_a[0] && !sw_rst
            |=> state_reg.creg[1][liu_regs_pkg::OFS_FLAGS_A][0];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("status rise not flagged"); // see (RULE12)

    property p_masked_quiet;
        (state_reg.creg[2][liu_regs_pkg::OFS_MASK_A] == 8'h00)
            && (state_reg.creg[2][liu_regs_pkg::OFS_MASK_B] == 8'h00) |-> !pend[2];
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked source pending"); // see (RULE6)

    property p_od_disabled;
        state_reg.gcfg[2] && !state_reg.gcfg[0] && !sw_rst |=> !irq_pin_oe_o;
    endproperty
    a_od_disabled: assert property (p_od_disabled) else $error("open drain driven while disabled"); // see (RULE6)

    property p_count_read;
        bus_i.rd && chan_hit && (chan_sel == 2'd1) && (ofs == liu_regs_pkg::OFS_COUNT_LO)
            |=> rdata_o == $past(chan_i[1].err_count[7:0]);
    endproperty
    a_count_read: assert property (p_count_read) else $error("counter read wrong"); // see (RULE1)

    property p_chan_odd_zero;
        bus_i.rd && (bus_i.addr == liu_regs_pkg::OFS_IRQ_CHANNEL)
            |=> (rdata_o[7] == 1'b0) && (rdata_o[5] == 1'b0) && (rdata_o[3] == 1'b0);
    endproperty
    a_chan_odd_zero: assert property (p_chan_odd_zero) else $error("channel indication spare bit"); // see (RULE11)

    property p_status_b_rsvd;
        bus_i.rd && chan_hit && (ofs == liu_regs_pkg::OFS_STATUS_B)
            |=> (rdata_o[7:6] == 2'b00) && (rdata_o[4:0] == 5'h00);
    endproperty
    a_status_b_rsvd: assert property (p_status_b_rsvd) else $error("status reserved bits set"); // see (RULE13)

    // Pin must be released on the very next edge, not just within the budget
    property p_sw_pin;
        sw_rst |=> !irq_pin_oe_o && !irq_pin_o && (state_reg.gcfg == liu_regs_pkg::GCFG_RST);
    endproperty
    a_sw_pin: assert property (p_sw_pin) else $error("ports not at default after soft reset"); // see (RULE2)

    property p_cov_w1c;
        bus_i.wr && chan_hit && (ofs == liu_regs_pkg::OFS_FLAGS_B);
    endproperty
    c_w1c: cover property (p_cov_w1c);

    property p_cov_std;
        !line_standard_select_o ##1 line_standard_select_o;
    endproperty
    c_std: cover property (p_cov_std);

    property p_cov_broadcast;
        bus_i.wr && copy_on && chan_hit;
    endproperty
    c_broadcast: cover property (p_cov_broadcast);

    property p_cov_irq;
        !pin_active ##1 pin_active;
    endproperty
    c_irq: cover property (p_cov_irq);

    property p_cov_sw_reset;
        sw_rst ##1 bus_i.rd;
    endproperty
    c_sw_reset: cover property (p_cov_sw_reset);
endmodule // quad_liu_register_map

/* File: tb/liu_host_model.sv */
// Host processor model driving the register bus
`timescale 1ns/1ps
module liu_host_model (
    input wire logic ref_clk_i,
    input wire logic [7:0] rdata_i,
    output liu_regs_pkg::bus_req_s bus_o
);
    initial begin
        bus_o = '0;
    end

    // One-cycle strobe; the slave never stalls, so no wait loop
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk_i);
        bus_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge ref_clk_i);
        bus_o <= '0;
    endtask

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge ref_clk_i);
        bus_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge ref_clk_i);
        bus_o <= '0;
        #1;
        data = rdata_i;
    endtask
endmodule // liu_host_model

/* File: tb/quad_liu_register_map_tb_top.sv */
// Self-checking testbench of the line interface register map
`timescale 1ns/1ps
module quad_liu_register_map_tb_top;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary value
    logic ref_clk_i;
    logic srst_i;
    liu_regs_pkg::bus_req_s bus;
    liu_regs_pkg::chan_in_s [liu_regs_pkg::NUM_CH-1:0] chan;
    logic [7:0] rdata;
    liu_regs_pkg::chan_regs_t [liu_regs_pkg::NUM_CH-1:0] chan_cfg;
    logic line_std;
    logic irq_pin;
    logic irq_oe;
    int errors;
    int compares;

    quad_liu_register_map #(.REVISION(REV)) u_dut (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .bus_i(bus),
        .chan_i(chan),
        .rdata_o(rdata),
        .chan_cfg_o(chan_cfg),
        .line_standard_select_o(line_std),
        .irq_pin_o(irq_pin),
        .irq_pin_oe_o(irq_oe)
    );

    liu_host_model u_host (
        .ref_clk_i(ref_clk_i),
        .rdata_i(rdata),
        .bus_o(bus)
    );

    initial begin
        ref_clk_i = 1'b0;
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic read_check(input logic [7:0] addr, input logic [7:0] exp, input string what);
        logic [7:0] d;
        u_host.read_reg(addr, d);
        check(d, exp, what);
    endtask

    task automatic pin_check(input logic oe, input logic pin, input string what);
        repeat (2) @(posedge ref_clk_i);
        #1;
        check({6'h00, irq_oe, irq_pin}, {6'h00, oe, pin}, what);
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        srst_i = 1'b1;
        chan = '0;
        repeat (20) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        read_check(8'h00, REV, "revision");
        read_check(8'h40, 8'h04, "gcfg default");
        pin_check(1'b0, 1'b0, "pin idle");
        check({7'h00, line_std}, 8'h00, "std default");
        u_host.write_reg(8'h00, 8'hff);
        read_check(8'h00, REV, "revision kept");
        $display("test defaults done");

        // Reserved top bits set, bit 5 kept zero
        u_host.write_reg(8'h40, 8'hd8);
        read_check(8'h40, 8'h18, "gcfg masked");
        check({7'h00, line_std}, 8'h01, "std t1");
        u_host.write_reg(8'h4d, 8'ha5);
        for (int c = 0; c < 4; c++) read_check({c[1:0], 6'h0d}, 8'ha5, "broadcast");
        u_host.write_reg(8'h40, 8'h00);
        // Register output settles after the edge that takes the write
        #1;
        check({7'h00, line_std}, 8'h00, "std e1");
        for (int c = 0; c < 4; c++) u_host.write_reg({c[1:0], 6'h0d}, {6'h04, c[1:0]});
        for (int c = 0; c < 4; c++) read_check({c[1:0], 6'h0d}, {6'h04, c[1:0]}, "bank");
        for (int c = 0; c < 4; c++) check(chan_cfg[c][13], {6'h04, c[1:0]}, "bank out");
        $display("test banks done");

        u_host.write_reg(8'ha0, 8'hff);
        read_check(8'ha0, 8'h00, "reserved addr");
        u_host.write_reg(8'h61, 8'hff);
        read_check(8'h61, 8'h00, "reserved gap");
        u_host.write_reg(8'h01, 8'hff);
        read_check(8'h01, 8'h3f, "reserved bits");
        @(posedge ref_clk_i);
        chan[1].err_count <= 16'hbeef;
        read_check(8'h58, 8'hef, "count low");
        read_check(8'h59, 8'hbe, "count high");
        $display("test reserved done");

        // Unmasked event on channel 3 with open-drain pin
        u_host.write_reg(8'h92, 8'h01);
        @(posedge ref_clk_i);
        chan[2].events <= 8'h01;
        @(posedge ref_clk_i);
        chan[2].events <= 8'h00;
        pin_check(1'b1, 1'b0, "open drain");
        read_check(8'h80, 8'h10, "channel flags");
        for (int m = 0; m < 4; m++) begin
            u_host.write_reg(8'h40, {6'h00, m[1:0]});
            pin_check(1'b1, m == 3, "pin mode");
        end
        u_host.write_reg(8'h40, 8'h07);
        pin_check(1'b1, 1'b0, "global off");
        read_check(8'h80, 8'h10, "flags kept");
        u_host.write_reg(8'h40, 8'h03);
        u_host.write_reg(8'h92, 8'h00);
        pin_check(1'b1, 1'b0, "masked");
        u_host.write_reg(8'h92, 8'h01);
        pin_check(1'b1, 1'b1, "unmasked");
        u_host.write_reg(8'h97, 8'h01);
        read_check(8'h97, 8'h00, "flag cleared");
        read_check(8'h80, 8'h00, "channel clear");
        pin_check(1'b1, 1'b0, "pin released");
        $display("test interrupt done");

        u_host.write_reg(8'h41, 8'h2a);
        u_host.write_reg(8'h40, 8'h13);
        u_host.write_reg(8'h20, 8'h5c);
        read_check(8'h40, 8'h04, "gcfg after soft");
        read_check(8'h41, 8'h00, "chan after soft");
        read_check(8'h20, 8'h00, "reset reg");
        check(chan_cfg[1][1], 8'h00, "chan out soft");
        check({6'h00, line_std, irq_oe}, 8'h00, "ports soft");
        $display("test soft reset done");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        $display("MISMATCH at %0t: run timed out", $time);
        finish_test();
    end
endmodule // quad_liu_register_map_tb_top
